// File: rtl/cmpev_pkg.sv
// constants and types of the comparator event block
package cmpev_pkg;
  localparam int ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [9:0] CSR_IDX = 10'h097;
  localparam logic [9:0] IRQ_EN_IDX = 10'h098;
  localparam logic [9:0] P3_IDX = 10'h099;
  // field positions
  localparam int SEL_LSB = 0;
  localparam int EN_BIT = 3;
  localparam int FLAG_BIT = 4;
  localparam int IDLE_BIT = 5;
  localparam int IRQ_EN_BIT = 6;
  localparam int PIN6_BIT = 6;
  // reset values
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] P3_RST = 8'hFF;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  // event select codes
  localparam logic [2:0] SEL_LOW = 3'h0;
  localparam logic [2:0] SEL_RISE = 3'h1;
  localparam logic [2:0] SEL_DB_TOG = 3'h2;
  localparam logic [2:0] SEL_DB_RISE = 3'h3;
  localparam logic [2:0] SEL_FALL = 3'h4;
  localparam logic [2:0] SEL_TOG = 3'h5;
  localparam logic [2:0] SEL_DB_FALL = 3'h6;
  localparam logic [2:0] SEL_HIGH = 3'h7;
  typedef struct packed {
    logic idle_run;
    logic flag;
    logic enable;
    logic [2:0] select;
  } cmpev_csr_t;
  typedef enum logic [1:0] {DB_IDLE, DB_WAIT1, DB_WAIT2} cmpev_db_t;
endpackage

// File: rtl/cmpev_top.sv
// comparator event, debounce and register logic
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cmpev_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cmpev_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_raw,
  input wire logic timer_ovf,
  input wire logic idle_mode,
  input wire logic powerdown_mode,
  input wire logic [7:0] port3_pins,
  output logic [7:0] port3_latch,
  output logic cmp_power_on,
  output logic irq,
  output logic wake_req
);
  // ********************
  // input synchronisers
  // ********************
  logic cmp_s1_reg;
  logic cmp_s2_reg;
  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      cmp_s1_reg <= cmp_raw;
      cmp_s2_reg <= cmp_s1_reg;
      pin_s1_reg <= port3_pins;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ********************
  // registers and bus
  // ********************
  cmpev_pkg::cmpev_csr_t csr_reg;
  logic irq_en_reg;
  logic active;
  logic cmp_res;
  logic pready_reg;
  logic [9:0] idx;
  logic acc;
  logic wr;
  logic hit;
  logic flag_clr;
  logic flag_set;
  logic flag_next;
  assign idx = paddr[11:2];
  assign hit = (idx == cmpev_pkg::CSR_IDX) || (idx == cmpev_pkg::IRQ_EN_IDX)
    || (idx == cmpev_pkg::P3_IDX);
  assign acc = psel && penable && !pready_reg;
  assign wr = psel && penable && pready_reg && pwrite && hit;
  assign flag_clr = wr && (idx == cmpev_pkg::CSR_IDX) && pwdata[cmpev_pkg::FLAG_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready_reg <= acc;
      pslverr <= acc && !hit;
      prdata <= 32'h0000_0000;
      if (acc && !pwrite) begin
        unique case (idx)
          cmpev_pkg::CSR_IDX: prdata <= {26'h0, csr_reg};
          cmpev_pkg::IRQ_EN_IDX: prdata <= {25'h0, irq_en_reg, 6'h00};
          cmpev_pkg::P3_IDX: prdata <= {24'h0, pin_s2_reg[7], cmp_res,
            pin_s2_reg[5:0]};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign pready = pready_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_reg <= cmpev_pkg::cmpev_csr_t'(cmpev_pkg::CSR_RST[5:0]);
      irq_en_reg <= cmpev_pkg::IRQ_EN_RST[cmpev_pkg::IRQ_EN_BIT];
    end else begin
      csr_reg.flag <= flag_next;
      if (wr && idx == cmpev_pkg::CSR_IDX) begin
        csr_reg.idle_run <= pwdata[cmpev_pkg::IDLE_BIT];
        csr_reg.enable <= pwdata[cmpev_pkg::EN_BIT];
        csr_reg.select <= pwdata[cmpev_pkg::SEL_LSB+:3];
      end
      if (wr && idx == cmpev_pkg::IRQ_EN_IDX) begin
        irq_en_reg <= pwdata[cmpev_pkg::IRQ_EN_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port3_latch <= cmpev_pkg::P3_RST;
    end else if (wr && idx == cmpev_pkg::P3_IDX) begin
      port3_latch <= pwdata[7:0];
    end
  end

  // ********************
  // comparator gating
  // ********************
  // enable gates comparator
  assign active = csr_reg.enable && !powerdown_mode
    && !(idle_mode && !csr_reg.idle_run);
  assign cmp_res = active && cmp_s2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_power_on <= 1'b0;
    end else begin
      cmp_power_on <= active;
    end
  end

  // ********************
  // event detection
  // ********************
  logic prev_reg;
  logic rise;
  logic fall;
  logic plain_ev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= cmp_res;
    end
  end
  assign rise = cmp_res && !prev_reg;
  assign fall = !cmp_res && prev_reg;

  always_comb begin
    unique case (csr_reg.select)
      cmpev_pkg::SEL_LOW: plain_ev = !cmp_res;
      cmpev_pkg::SEL_RISE: plain_ev = rise;
      cmpev_pkg::SEL_FALL: plain_ev = fall;
      cmpev_pkg::SEL_TOG: plain_ev = rise || fall;
      cmpev_pkg::SEL_HIGH: plain_ev = cmp_res;
      default: plain_ev = 1'b0;
    endcase
  end

  // ********************
  // debounce sequencer
  // ********************
  cmpev_pkg::cmpev_db_t db_reg;
  logic expect_reg;
  logic db_start;
  logic db_ev;
  always_comb begin
    unique case (csr_reg.select)
      cmpev_pkg::SEL_DB_TOG: db_start = rise || fall;
      cmpev_pkg::SEL_DB_RISE: db_start = rise;
      cmpev_pkg::SEL_DB_FALL: db_start = fall;
      default: db_start = 1'b0;
    endcase
  end
  assign db_ev = (db_reg == cmpev_pkg::DB_WAIT2) && timer_ovf
    && (cmp_res == expect_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_reg <= cmpev_pkg::DB_IDLE;
      expect_reg <= 1'b0;
    end else if (!active) begin
      db_reg <= cmpev_pkg::DB_IDLE;
    end else begin
      unique case (db_reg)
        cmpev_pkg::DB_IDLE: begin
          if (db_start) begin
            db_reg <= cmpev_pkg::DB_WAIT1;
            expect_reg <= cmp_res;
          end
        end
        cmpev_pkg::DB_WAIT1: begin
          if (timer_ovf) begin
            db_reg <= cmpev_pkg::DB_WAIT2;
          end
        end
        cmpev_pkg::DB_WAIT2: begin
          if (timer_ovf) begin
            db_reg <= cmpev_pkg::DB_IDLE;
          end
        end
        default: db_reg <= cmpev_pkg::DB_IDLE;
      endcase
    end
  end

  // ********************
  // flag and interrupt
  // ********************
  // set only while active
  assign flag_set = active && (plain_ev || db_ev);
  assign flag_next = flag_set || (csr_reg.flag && !flag_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq <= flag_next && irq_en_reg;
      wake_req <= flag_next && irq_en_reg && idle_mode && csr_reg.idle_run
        && !powerdown_mode;
    end
  end

  // ********************
  // assertions
  // ********************
  property p_en_off;
    @(posedge pclk) disable iff (!presetn) !csr_reg.enable |=> !cmp_power_on;
  endproperty
  a_en_off: assert property (p_en_off) else $error("on while disabled");

  property p_pd_off;
    @(posedge pclk) disable iff (!presetn) powerdown_mode |=> !cmp_power_on;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("on in power-down");

  property p_idle_off;
    @(posedge pclk) disable iff (!presetn)
      idle_mode && !csr_reg.idle_run |=> !cmp_power_on;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("on in idle");

  property p_no_set_off;
    @(posedge pclk) disable iff (!presetn)
      !active && !csr_reg.flag |=> !csr_reg.flag;
  endproperty
  a_no_set_off: assert property (p_no_set_off) else $error("set while off");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      csr_reg.flag && !flag_clr |=> csr_reg.flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      irq == (csr_reg.flag && $past(irq_en_reg));
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");

  property p_rise;
    @(posedge pclk) disable iff (!presetn)
      csr_reg.select == cmpev_pkg::SEL_RISE && active && rise |=> csr_reg.flag;
  endproperty
  a_rise: assert property (p_rise) else $error("rise missed");

  property p_db;
    @(posedge pclk) disable iff (!presetn)
      db_reg == cmpev_pkg::DB_WAIT1 && timer_ovf && active
      |=> db_reg == cmpev_pkg::DB_WAIT2;
  endproperty
  a_db: assert property (p_db) else $error("debounce stuck");

  property p_db_set;
    @(posedge pclk) disable iff (!presetn)
      $rose(csr_reg.flag) && csr_reg.select[1] && csr_reg.select != cmpev_pkg::SEL_HIGH
      |-> $past(db_reg) == cmpev_pkg::DB_WAIT2 && $past(timer_ovf);
  endproperty
  a_db_set: assert property (p_db_set) else $error("debounce early");
endmodule
`default_nettype wire

// File: verif/cmpev_partner.sv
// partner model: analog comparator stage and free-running timer
`timescale 1ns/1ps
`default_nettype none
module cmpev_partner #(
  parameter int TMR_PERIOD = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on,
  input wire logic [7:0] pos_lvl,
  input wire logic [7:0] neg_lvl,
  output logic cmp_raw,
  output logic timer_ovf
);
  // ****************
  // analog stage and timer
  // ****************
  logic noise_reg;
  int tcnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise_reg <= 1'b0;
      tcnt_reg <= 0;
    end else begin
      noise_reg <= ~noise_reg;
      tcnt_reg <= (tcnt_reg == TMR_PERIOD - 1) ? 0 : tcnt_reg + 1;
    end
  end
  assign cmp_raw = power_on ? (pos_lvl > neg_lvl) : noise_reg;
  assign timer_ovf = (tcnt_reg == TMR_PERIOD - 1);
endmodule
`default_nettype wire

// File: verif/cmpev_top_tb.sv
// testbench of the comparator event block
`timescale 1ns/1ps
`default_nettype none
module cmpev_top_tb;
  localparam logic [9:0] CSR = cmpev_pkg::CSR_IDX;
  localparam logic [9:0] IEN = cmpev_pkg::IRQ_EN_IDX;
  localparam logic [9:0] P3 = cmpev_pkg::P3_IDX;
  localparam logic [7:0] EXP_R = 8'hAF;
  localparam logic [7:0] EXP_F = 8'hF5;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0] pos_lvl = 8'h10;
  logic [7:0] neg_lvl = 8'h80;
  logic idle_mode = 1'b0;
  logic powerdown_mode = 1'b0;
  logic [7:0] pins = 8'hA5;
  logic [31:0] prdata, rd_data;
  logic pready, pslverr, rd_err, cmp_raw, timer_ovf, cmp_power_on, irq, wake_req;
  logic [7:0] port3_latch;
  int n_fail = 0;
  int checked = 0;
  always #4 pclk = ~pclk;
  cmpev_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_raw(cmp_raw), .timer_ovf(timer_ovf), .idle_mode(idle_mode),
    .powerdown_mode(powerdown_mode), .port3_pins(pins), .port3_latch(port3_latch),
    .cmp_power_on(cmp_power_on), .irq(irq), .wake_req(wake_req));
  cmpev_partner #(.TMR_PERIOD(16)) far (.pclk(pclk), .presetn(presetn),
    .power_on(cmp_power_on), .pos_lvl(pos_lvl), .neg_lvl(neg_lvl), .cmp_raw(cmp_raw),
    .timer_ovf(timer_ovf));
  // ****************
  // tasks
  // ****************
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, "apb timeout");
      complete_run();
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    wt(2);
    presetn <= 1'b1;
    apb(0, CSR, 8'h00);
    chk(rd_data, 32'h0, "csr reset");
    apb(0, IEN, 8'h00);
    chk(rd_data, 32'h0, "irq enable reset");
    chk({24'h0, port3_latch}, {24'h0, cmpev_pkg::P3_RST}, "latch reset");
    apb(0, 10'h000, 8'h00);
    chk({31'h0, rd_err}, 32'h1, "unmapped");
    $display("test reset done");
    apb(1, CSR, 8'h08);
    wt(cmpev_pkg::SETTLE_CYC);
    for (int c = 0; c < 8; c++) begin
      pos_lvl <= 8'h10;
      apb(1, CSR, {5'b00001, c[2:0]});
      wt(60);
      apb(1, CSR, {5'b00011, c[2:0]});
      pos_lvl <= 8'hF0;
      wt(60);
      apb(0, CSR, 8'h00);
      chk({31'h0, rd_data[4]}, {31'h0, EXP_R[c]}, "rise flag");
      apb(1, CSR, {5'b00011, c[2:0]});
      pos_lvl <= 8'h10;
      wt(60);
      apb(0, CSR, 8'h00);
      chk({31'h0, rd_data[4]}, {31'h0, EXP_F[c]}, "fall flag");
    end
    $display("test modes done");
    pos_lvl <= 8'hF0;
    apb(1, CSR, 8'h0E);
    wt(60);
    apb(1, CSR, 8'h1E);
    pos_lvl <= 8'h10;
    wt(4);
    pos_lvl <= 8'hF0;
    wt(60);
    apb(0, CSR, 8'h00);
    chk(rd_data, 32'h0E, "glitch dropped");
    $display("test debounce done");
    apb(1, CSR, 8'h1F);
    wt(5);
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1, IEN, 8'h40);
    wt(3);
    chk({31'h0, irq}, 32'h1, "irq raised");
    idle_mode <= 1'b1;
    wt(4);
    chk({30'h0, cmp_power_on, wake_req}, 32'h0, "idle stop");
    apb(1, CSR, 8'h2F);
    wt(5);
    chk({30'h0, cmp_power_on, wake_req}, 32'h3, "idle run wake");
    powerdown_mode <= 1'b1;
    wt(4);
    chk({31'h0, cmp_power_on}, 32'h0, "power-down stop");
    idle_mode <= 1'b0;
    powerdown_mode <= 1'b0;
    apb(1, IEN, 8'h00);
    wt(3);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test irq done");
    apb(1, CSR, 8'h18);
    wt(5);
    apb(0, P3, 8'h00);
    chk(rd_data, 32'hE5, "pin six live");
    apb(1, P3, 8'h00);
    wt(1);
    chk({23'h0, cmp_power_on, port3_latch}, 32'h100, "latch only");
    apb(0, P3, 8'h00);
    chk(rd_data, 32'hE5, "pin six kept");
    apb(1, CSR, 8'h00);
    pins <= 8'hE5;
    wt(5);
    apb(0, P3, 8'h00);
    chk(rd_data, 32'hA5, "disabled low");
    chk({31'h0, cmp_power_on}, 32'h0, "power off");
    $display("test port done");
    apb(1, CSR, 8'h2F);
    apb(1, IEN, 8'h40);
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    apb(0, CSR, 8'h00);
    chk(rd_data, 32'h0, "csr mid reset");
    apb(0, IEN, 8'h00);
    chk(rd_data, 32'h0, "irq enable mid reset");
    chk({22'h0, irq, wake_req, port3_latch}, {24'h0, cmpev_pkg::P3_RST}, "mid outputs");
    $display("test mid reset done");
    complete_run();
  end
endmodule
`default_nettype wire
